// >>> rtl/i2c_master_sequencer_regs.vh
// Constants for the two-wire master sequencer.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef I2C_MASTER_SEQUENCER_REGS_VH
`define I2C_MASTER_SEQUENCER_REGS_VH

// Baud reload field, bits 7:0
`define BAUD_MSB 7
`define BAUD_W 8
// Index of the last data bit and of the acknowledge bit time
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8
// Receive buffer depth
`define RX_DEPTH 2
// Reset values
`define BYTE_RESET 8'h00
`define CNT_RESET 8'h00

`endif

// >>> rtl/rx_pair_buffer.v
// Two-entry receive buffer with valid and ready on both sides.
// Assumes a single clock; pushes only while in_ready is high.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_sequencer_regs.vh"

module rx_pair_buffer (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [7:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [7:0] out_data
);
   reg [7:0] head_r;
   reg [7:0] tail_r;
   reg head_v_r;
   reg tail_v_r;
   wire push;
   wire pop;

   // Output words come straight from the head register
   assign out_data = head_r;
   assign out_valid = head_v_r;
   assign in_ready = ~tail_v_r;
   assign push = in_valid & ~tail_v_r;
   assign pop = head_v_r & out_ready;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         head_r <= `BYTE_RESET;
         tail_r <= `BYTE_RESET;
         head_v_r <= 1'b0;
         tail_v_r <= 1'b0;
      end else begin
         if (pop) begin
            // Tail moves up; no push lands in the same cycle, since in_ready is low while the tail is full
            if (tail_v_r) begin
               head_r <= tail_r;
               tail_v_r <= 1'b0;
               if (push) begin
                  tail_r <= in_data;
                  tail_v_r <= 1'b1;
               end
            end else if (push) begin
               head_r <= in_data;
            end else begin
               head_v_r <= 1'b0;
            end
         end else if (push) begin
            if (head_v_r) begin
               tail_r <= in_data;
               tail_v_r <= 1'b1;
            end else begin
               head_r <= in_data;
               head_v_r <= 1'b1;
            end
         end
      end
   end
endmodule // rx_pair_buffer
`default_nettype wire

// >>> rtl/i2c_master_sequencer.v
// Master-side sequencer for a two-wire serial bus: Start, Repeated Start,
// byte transmit with acknowledge capture, byte receive, acknowledge send.
// Assumes clk at 25 MHz; bus pins arrive asynchronous and are synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_sequencer_regs.vh"

module i2c_master_sequencer (
   input wire clk,
   input wire rst_n,
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire [`BAUD_MSB:0] baud_reload,
   input wire start_set,
   input wire repeated_start_set,
   input wire receive_enable_set,
   input wire ack_sequence_set,
   input wire ack_data_value,
   input wire tx_write,
   input wire [7:0] tx_data,
   output wire [7:0] rx_data,
   output wire rx_valid,
   input wire rx_ready,
   input wire int_clear,
   input wire collision_clear,
   input wire write_collision_clear,
   input wire overflow_clear,
   input wire start_detected_clear,
   output wire start_request,
   output wire repeated_start_request,
   output wire receive_enable,
   output wire ack_sequence_enable,
   output wire start_detected,
   output wire buffer_full,
   output wire write_collision,
   output wire receive_overflow,
   output wire ack_status,
   output wire port_interrupt_flag,
   output wire collision_flag
);
   ////////////////////////////////////////////////////////////////////////
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ST_WAIT = 4'h1;
   localparam [3:0] S_ST_HOLD = 4'h2;
   localparam [3:0] S_RS_SCLLOW = 4'h3;
   localparam [3:0] S_RS_SDAHI = 4'h4;
   localparam [3:0] S_RS_SCLREL = 4'h5;
   localparam [3:0] S_RS_BOTH = 4'h6;
   localparam [3:0] S_RS_SDALOW = 4'h7;
   localparam [3:0] S_B_LOW = 4'h8;
   localparam [3:0] S_B_WAITH = 4'h9;
   localparam [3:0] S_B_HIGH = 4'ha;

   localparam [1:0] M_TX = 2'h0;
   localparam [1:0] M_RX = 2'h1;
   localparam [1:0] M_AK = 2'h2;

   function both_high;
      input a;
      input b;
      begin
         both_high = a & b;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read
   reg scl_m_r;
   reg scl_s_r;
   reg sda_m_r;
   reg sda_s_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else begin
         scl_m_r <= scl_in;
         scl_s_r <= scl_m_r;
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   reg [3:0] state_r;
   reg [1:0] mode_r;
   reg [`BAUD_MSB:0] cnt_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg scl_oe_r;
   reg sda_oe_r;
   reg sen_r;
   reg repeated_start_request_r;
   reg receive_enable_r;
   reg ack_sequence_enable_r;
   reg sdet_r;
   reg bf_r;
   reg write_collision_r;
   reg ov_r;
   reg ackst_r;
   reg pif_r;
   reg bcl_r;
   reg push_r;
   wire tick;
   wire counting;
   wire idle;
   wire fifo_in_ready;
   wire pop;

   assign tick = (cnt_r == `CNT_RESET);
   assign idle = (state_r == S_IDLE);
   // Wait states keep the counter halted while the clock line is stretched
   assign counting = (state_r == S_ST_WAIT) | (state_r == S_ST_HOLD) |
      (state_r == S_RS_SDAHI) | (state_r == S_RS_BOTH) |
      (state_r == S_RS_SDALOW) | (state_r == S_B_LOW) | (state_r == S_B_HIGH);
   assign pop = rx_valid & rx_ready;

   rx_pair_buffer u_rx_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push_r),
      .in_ready(fifo_in_ready),
      .in_data(shift_r),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         mode_r <= M_TX;
         cnt_r <= `CNT_RESET;
         bit_cnt_r <= 4'h0;
         shift_r <= `BYTE_RESET;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         sen_r <= 1'b0;
         repeated_start_request_r <= 1'b0;
         receive_enable_r <= 1'b0;
         ack_sequence_enable_r <= 1'b0;
         sdet_r <= 1'b0;
         bf_r <= 1'b0;
         write_collision_r <= 1'b0;
         ov_r <= 1'b0;
         ackst_r <= 1'b0;
         pif_r <= 1'b0;
         bcl_r <= 1'b0;
         push_r <= 1'b0;
      end else begin
         // Clears first, so a set later in this cycle wins
         if (int_clear) pif_r <= 1'b0;
         if (collision_clear) bcl_r <= 1'b0;
         if (write_collision_clear) write_collision_r <= 1'b0;
         if (overflow_clear) ov_r <= 1'b0;
         if (start_detected_clear) sdet_r <= 1'b0;
         if (pop) bf_r <= 1'b0;
         push_r <= 1'b0;
         if (counting && !tick) cnt_r <= cnt_r - 8'h01;

         // Refused write leaves the shift register untouched
         if (tx_write && (!idle || write_collision_r)) write_collision_r <= 1'b1;

         case (state_r)
            S_IDLE: begin
               if (tx_write && !write_collision_r) begin
                  shift_r <= tx_data;
                  bf_r <= 1'b1;
                  bit_cnt_r <= 4'h0;
                  mode_r <= M_TX;
                  scl_oe_r <= 1'b1;
                  sda_oe_r <= ~tx_data[7];
                  cnt_r <= baud_reload;
                  state_r <= S_B_LOW;
               end else if (start_set) begin
                  if (both_high(scl_s_r, sda_s_r)) begin
                     sen_r <= 1'b1;
                     cnt_r <= baud_reload;
                     state_r <= S_ST_WAIT;
                  end else begin
                     bcl_r <= 1'b1;
                  end
               end else if (repeated_start_set) begin
                  repeated_start_request_r <= 1'b1;
                  scl_oe_r <= 1'b1;
                  state_r <= S_RS_SCLLOW;
               end else if (receive_enable_set && fifo_in_ready) begin
                  receive_enable_r <= 1'b1;
                  mode_r <= M_RX;
                  bit_cnt_r <= 4'h0;
                  scl_oe_r <= 1'b1;
                  sda_oe_r <= 1'b0;
                  cnt_r <= baud_reload;
                  state_r <= S_B_LOW;
               end else if (ack_sequence_set) begin
                  ack_sequence_enable_r <= 1'b1;
                  mode_r <= M_AK;
                  scl_oe_r <= 1'b1;
                  sda_oe_r <= ~ack_data_value;
                  cnt_r <= baud_reload;
                  state_r <= S_B_LOW;
               end
            end
            S_ST_WAIT: begin
               if (!scl_s_r || (tick && !sda_s_r)) begin
                  sen_r <= 1'b0;
                  bcl_r <= 1'b1;
                  state_r <= S_IDLE;
               end else if (tick) begin
                  sda_oe_r <= 1'b1;
                  sdet_r <= 1'b1;
                  cnt_r <= baud_reload;
                  state_r <= S_ST_HOLD;
               end
            end
            S_ST_HOLD: begin
               if (tick) begin
                  sen_r <= 1'b0;
                  pif_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_RS_SCLLOW: begin
               if (!scl_s_r) begin
                  sda_oe_r <= 1'b0;
                  cnt_r <= baud_reload;
                  state_r <= S_RS_SDAHI;
               end
            end
            S_RS_SDAHI: begin
               if (tick) begin
                  if (sda_s_r) begin
                     scl_oe_r <= 1'b0;
                     state_r <= S_RS_SCLREL;
                  end else begin
                     repeated_start_request_r <= 1'b0;
                     bcl_r <= 1'b1;
                     scl_oe_r <= 1'b0;
                     state_r <= S_IDLE;
                  end
               end
            end
            S_RS_SCLREL: begin
               if (scl_s_r) begin
                  if (!sda_s_r) begin
                     repeated_start_request_r <= 1'b0;
                     bcl_r <= 1'b1;
                     state_r <= S_IDLE;
                  end else begin
                     cnt_r <= baud_reload;
                     state_r <= S_RS_BOTH;
                  end
               end
            end
            S_RS_BOTH: begin
               if (!both_high(scl_s_r, sda_s_r)) begin
                  repeated_start_request_r <= 1'b0;
                  bcl_r <= 1'b1;
                  state_r <= S_IDLE;
               end else if (tick) begin
                  sda_oe_r <= 1'b1;
                  sdet_r <= 1'b1;
                  cnt_r <= baud_reload;
                  state_r <= S_RS_SDALOW;
               end
            end
            S_RS_SDALOW: begin
               if (tick) begin
                  // Counter is not reloaded; it stays at zero while idle
                  scl_oe_r <= 1'b1;
                  repeated_start_request_r <= 1'b0;
                  pif_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_B_LOW: begin
               if (tick) begin
                  scl_oe_r <= 1'b0;
                  state_r <= S_B_WAITH;
               end
            end
            S_B_WAITH: begin
               // Another device may stretch the clock low here
               if (scl_s_r) begin
                  cnt_r <= baud_reload;
                  state_r <= S_B_HIGH;
               end
            end
            S_B_HIGH: begin
               if (tick) begin
                  scl_oe_r <= 1'b1;
                  cnt_r <= baud_reload;
                  state_r <= S_B_LOW;
                  case (mode_r)
                     M_TX: begin
                        if (bit_cnt_r == `ACK_BIT) begin
                           ackst_r <= sda_s_r;
                           pif_r <= 1'b1;
                           state_r <= S_IDLE;
                        end else begin
                           bit_cnt_r <= bit_cnt_r + 4'h1;
                           shift_r <= {shift_r[6:0], 1'b0};
                           sda_oe_r <= ~shift_r[6];
                           if (bit_cnt_r == `LAST_DATA_BIT) begin
                              bf_r <= 1'b0;
                              sda_oe_r <= 1'b0;
                           end
                        end
                     end
                     M_RX: begin
                        shift_r <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `LAST_DATA_BIT) begin
                           receive_enable_r <= 1'b0;
                           push_r <= 1'b1;
                           bf_r <= 1'b1;
                           pif_r <= 1'b1;
                           if (bf_r && !pop) ov_r <= 1'b1;
                           state_r <= S_IDLE;
                        end
                     end
                     default: begin
                        ack_sequence_enable_r <= 1'b0;
                        pif_r <= 1'b1;
                        state_r <= S_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Pin output levels are always low; only the enables move
   reg scl_out_r;
   reg sda_out_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end else begin
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign scl_out = scl_out_r;
   assign sda_out = sda_out_r;
   assign scl_oe = scl_oe_r;
   assign sda_oe = sda_oe_r;
   assign start_request = sen_r;
   assign repeated_start_request = repeated_start_request_r;
   assign receive_enable = receive_enable_r;
   assign ack_sequence_enable = ack_sequence_enable_r;
   assign start_detected = sdet_r;
   assign buffer_full = bf_r;
   assign write_collision = write_collision_r;
   assign receive_overflow = ov_r;
   assign ack_status = ackst_r;
   assign port_interrupt_flag = pif_r;
   assign collision_flag = bcl_r;
endmodule // i2c_master_sequencer
`default_nettype wire

// >>> bench/i2c_master_sequencer_assertions.sv
// Port checker for the two-wire master sequencer.
// Assumes it is bound into the sequencer top; bus pins seen as raw levels.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_sequencer_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic [7:0] baud_reload,
   input wire logic start_set,
   input wire logic repeated_start_set,
   input wire logic tx_write,
   input wire logic [7:0] tx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic start_request,
   input wire logic repeated_start_request,
   input wire logic receive_enable,
   input wire logic ack_sequence_enable,
   input wire logic start_detected,
   input wire logic buffer_full,
   input wire logic write_collision,
   input wire logic receive_overflow,
   input wire logic port_interrupt_flag,
   input wire logic collision_flag
);
   // Transmit ack phase is invisible here, so busy is a lower bound
   wire busy = start_request | repeated_start_request | receive_enable | ack_sequence_enable
      | buffer_full;
   logic [9:0] cnt_r;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_r <= 10'h000;
      else cnt_r <= start_request ? cnt_r + 10'h001 : 10'h000;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_start_delay: assert property ($rose(sda_oe) && start_request |->
      cnt_r == {2'b00, baud_reload} + 10'h001) else $error("start edge off one period");
   a_start_done: assert property ($fell(start_request) && !collision_flag |->
      port_interrupt_flag && sda_oe && !scl_oe) else $error("start end state wrong");
   a_start_coll: assert property ((!scl_in && !sda_in)[*3] ##0 (start_set && !busy) |->
      ##[1:2] collision_flag) else $error("start on low lines not refused");
   a_rs_ignored: assert property (repeated_start_set && busy |=>
      !$rose(repeated_start_request)) else $error("restart taken while busy");
   a_rs_done: assert property ($fell(repeated_start_request) && !collision_flag |->
      scl_oe && sda_oe && port_interrupt_flag && start_detected) else $error("restart end wrong");
   a_tx_launch: assert property (tx_write && !write_collision && !busy |=>
      buffer_full && scl_oe && sda_oe == !$past(tx_data[7])) else $error("transmit launch wrong");
   a_tx_stable: assert property (buffer_full && !scl_oe && $past(scl_oe) == 1'b0 |->
      $stable(sda_oe)) else $error("data moved while clock high");
   a_write_coll: assert property (tx_write && busy |=> write_collision)
      else $error("busy write not flagged");
   a_ack_release: assert property ($fell(buffer_full) && !($past(rx_valid) && $past(rx_ready))
      |-> !sda_oe) else $error("data line kept after eighth bit");
   a_rx_done: assert property ($fell(receive_enable) && !collision_flag |->
      buffer_full && port_interrupt_flag && scl_oe && (!$past(buffer_full) || receive_overflow))
      else $error("receive end wrong");
   a_pop_clear: assert property (rx_valid && rx_ready && !receive_enable |=> !buffer_full)
      else $error("read kept buffer full");
   c_start: cover property ($fell(start_request) && port_interrupt_flag);
   c_restart: cover property ($fell(repeated_start_request) && !collision_flag);
   c_overflow: cover property ($rose(receive_overflow));
endmodule // i2c_master_sequencer_assertions
`default_nettype wire

// >>> bench/bus_slave_model.sv
// Behavioural slave on the two-wire bus; it decodes no address and answers only the first byte after each sync.
// Assumes pulled-up lines resolved by the bench; it only ever pulls low.
`timescale 1ns/1ns
`default_nettype none
module bus_slave_model (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic sync,
   input wire logic rd_mode,
   input wire logic ack_en,
   input wire logic [7:0] rd_byte,
   input wire logic [7:0] stretch,
   output wire logic scl_pull,
   output wire logic sda_pull,
   output logic [7:0] got
);
   logic scl_d = 1'b1;
   logic [3:0] rise = 4'h0;
   logic [3:0] idx = 4'h0;
   logic [7:0] hold = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      scl_d <= scl;
      if (sync) begin
         rise <= 4'h0;
         idx <= 4'h0;
         got <= 8'h00;
      end else if (scl && !scl_d) begin
         rise <= rise + 4'h1;
         if (rise < 4'h8) got <= {got[6:0], sda};
      end else if (!scl && scl_d) begin
         // Bit index moves only on a fall, so data holds through the high phase
         idx <= rise;
         hold <= stretch;
      end else if (hold != 8'h00) hold <= hold - 8'h01;
   end
   assign scl_pull = hold != 8'h00;
   assign sda_pull = rd_mode ? (idx < 4'h8 && !rd_byte[3'h7 - idx[2:0]])
      : (ack_en && idx == 4'h8);
endmodule // bus_slave_model
`default_nettype wire

// >>> bench/tb_i2c_master_sequencer.sv
// Self-checking bench for the two-wire master sequencer.
// Assumes pulled-up bus lines; every party only pulls low.
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_master_sequencer;
   localparam int T = 3;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [10:0] stb = 11'h000;
   logic [7:0] tx_data = 8'h00, rd_byte = 8'h00, stretch = 8'h00, baud = 8'h02;
   logic ack_data_value = 1'b0, rx_ready = 1'b0, hold_scl = 1'b0, hold_sda = 1'b0;
   logic sl_ack = 1'b0, rd_mode = 1'b0;
   logic [9:0] hi = 10'h000, min_hi = 10'h3ff;
   int fail_count = 0, n_checks = 0, n = 0, cyc = 0;
   wire scl_oe, scl_out, sda_oe, sda_out, rx_valid, s_scl, s_sda, ack_status;
   wire start_request, repeated_start_request, receive_enable, ack_sequence_enable;
   wire start_detected, buffer_full, write_collision, receive_overflow;
   wire port_interrupt_flag, collision_flag;
   wire [7:0] rx_data, s_got;
   wire scl_w = !((scl_oe && !scl_out) || s_scl || hold_scl);
   wire sda_w = !((sda_oe && !sda_out) || s_sda || hold_sda);
   wire [6:0] dn = {rx_valid, !ack_sequence_enable, !receive_enable, port_interrupt_flag,
      !repeated_start_request, !start_request, sda_oe};
   ////////////////////////////////////////////////////////////////////////////
   always #20 clk = ~clk;
   i2c_master_sequencer dut (.clk(clk), .rst_n(rst_n), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .baud_reload(baud), .start_set(stb[0]), .repeated_start_set(stb[1]),
      .receive_enable_set(stb[2]), .ack_sequence_set(stb[3]), .ack_data_value(ack_data_value),
      .tx_write(stb[4]), .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .int_clear(stb[5]), .collision_clear(stb[6]),
      .write_collision_clear(stb[7]), .overflow_clear(stb[8]), .start_detected_clear(stb[9]),
      .start_request(start_request), .repeated_start_request(repeated_start_request),
      .receive_enable(receive_enable), .ack_sequence_enable(ack_sequence_enable),
      .start_detected(start_detected), .buffer_full(buffer_full),
      .write_collision(write_collision), .receive_overflow(receive_overflow),
      .ack_status(ack_status), .port_interrupt_flag(port_interrupt_flag),
      .collision_flag(collision_flag));
   bus_slave_model slave (.clk(clk), .scl(scl_w), .sda(sda_w), .sync(stb[10]),
      .rd_mode(rd_mode), .ack_en(sl_ack), .rd_byte(rd_byte), .stretch(stretch),
      .scl_pull(s_scl), .sda_pull(s_sda), .got(s_got));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (scl_w) hi <= hi + 10'h001;
      else begin
         if (hi != 10'h000 && hi < min_hi) min_hi <= hi;
         hi <= 10'h000;
      end
      if (cyc == 20000) begin
         fail_count++;
         summarize;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Gap cycle after each strobe so back-to-back calls never collide
   task ps(input int k);
      stb = 11'h001 << k;
      @(negedge clk);
      stb = 11'h000;
      @(negedge clk);
   endtask
   task wt(input int k);
      n = 0;
      while (dn[k] !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n == 3000) fail_count++;
   endtask
   task t_coll;
      {hold_scl, hold_sda} = 2'b11;
      repeat (4) @(negedge clk);
      ps(0);
      chk(collision_flag, 1'b1);
      chk(start_request, 1'b0);
      {hold_scl, hold_sda} = 2'b00;
      ps(6);
      repeat (3) @(negedge clk);
      // Clock pulled with the request, so it is seen low during the count
      hold_scl = 1'b1;
      ps(0);
      repeat (4) @(negedge clk);
      chk({collision_flag, sda_oe}, 8'h02);
      hold_scl = 1'b0;
      ps(6);
      $display("t_coll done");
   endtask
   task t_start;
      // Other reload value; first period loses one cycle inside ps
      baud = 8'h04;
      ps(0);
      wt(0);
      chk(n, baud);
      chk({start_detected, scl_w}, 8'h03);
      wt(1);
      chk(n, baud + 8'h01);
      chk({port_interrupt_flag, sda_oe}, 8'h03);
      chk({scl_out, sda_out}, 8'h00);
      ps(5);
      baud = 8'h02;
      $display("t_start done");
   endtask
   task t_tx(input logic [7:0] b, input logic a, input logic [7:0] st);
      {sl_ack, stretch, tx_data} = {a, st, b};
      ps(10);
      ps(4);
      chk(buffer_full, 1'b1);
      ps(4);
      chk(write_collision, 1'b1);
      ps(7);
      ps(1);
      chk(repeated_start_request, 1'b0);
      ps(2);
      chk(receive_enable, 1'b0);
      wt(3);
      chk(s_got, b);
      chk(ack_status, !a);
      chk({buffer_full, scl_oe}, 8'h01);
      ps(5);
      $display("t_tx done");
   endtask
   task t_rs;
      ps(9);
      ps(1);
      wt(2);
      chk({start_detected, port_interrupt_flag}, 8'h03);
      chk({sda_oe, scl_oe, collision_flag}, 8'h06);
      ps(5);
      $display("t_rs done");
   endtask
   task t_rx(input logic [7:0] b, input logic ov);
      {rd_mode, rd_byte} = {1'b1, b};
      ps(10);
      ps(2);
      wt(4);
      chk({buffer_full, port_interrupt_flag, scl_oe}, 8'h07);
      chk(receive_overflow, ov);
      ps(5);
      // Last byte of the read ends with a not-acknowledge
      ack_data_value = ov;
      ps(3);
      wt(5);
      chk(sda_oe, !ov);
      rd_mode = 1'b0;
      ps(5);
      $display("t_rx done");
   endtask
   task t_drain;
      ps(2);
      chk(receive_enable, 1'b0);
      chk(rx_data, 8'h3c);
      rx_ready = 1'b1;
      @(negedge clk);
      chk(buffer_full, 1'b0);
      chk(rx_data, 8'hc3);
      @(negedge clk);
      rx_ready = 1'b0;
      chk(rx_valid, 1'b0);
      hold_sda = 1'b1;
      ps(1);
      wt(2);
      chk(collision_flag, 1'b1);
      hold_sda = 1'b0;
      $display("t_drain done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_coll;
      t_start;
      t_tx(8'ha6, 1'b1, 8'h00);
      t_tx(8'h5b, 1'b0, 8'h14);
      chk(min_hi >= T, 1'b1);
      t_rs;
      t_tx(8'ha7, 1'b1, 8'h00);
      t_rx(8'h3c, 1'b0);
      t_rx(8'hc3, 1'b1);
      t_drain;
      summarize;
   end
endmodule // tb_i2c_master_sequencer
bind i2c_master_sequencer i2c_master_sequencer_assertions chk_i (.clk(clk), .rst_n(rst_n),
   .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .baud_reload(baud_reload), .start_set(start_set), .repeated_start_set(repeated_start_set),
   .tx_write(tx_write), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .start_request(start_request), .repeated_start_request(repeated_start_request),
   .receive_enable(receive_enable), .ack_sequence_enable(ack_sequence_enable),
   .start_detected(start_detected), .buffer_full(buffer_full),
   .write_collision(write_collision), .receive_overflow(receive_overflow),
   .port_interrupt_flag(port_interrupt_flag), .collision_flag(collision_flag));
`default_nettype wire
